// File: sew_pkg.sv
// Shared constants for the two-wire EEPROM slave write path.
// Assumes a 50 MHz core clock; bus pins arrive asynchronous.
package sew_pkg;
  // ----------------------------------------------------------------
  // Addressing
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 15;
  localparam int          PAGE_W      = 6;
  localparam int          PAGE_BYTES  = 64;
  localparam logic [3:0]  TYPE_CODE   = 4'h5; // Arbitrary device type code
  localparam logic [3:0]  BIT_LAST    = 4'h7;
  localparam logic [3:0]  BIT_ACK     = 4'h8;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_HZ      = 50000000;
  localparam int          TWC_MS      = 5;
  localparam int          TWC_CYC     = (CLK_HZ / 1000) * TWC_MS;
  localparam int          CNT_W       = 18;
  // ----------------------------------------------------------------
  // Byte phases
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    SEW_IDLE  = 6'h01,
    SEW_CTRL  = 6'h02,
    SEW_ADRH  = 6'h04,
    SEW_ADRL  = 6'h08,
    SEW_DATA  = 6'h10,
    SEW_SKIP  = 6'h20
  } sew_phase_e;
endpackage

// File: sew_slave.sv
// Two-wire EEPROM slave front end: framing, addressing, page-buffered write.
// Assumes the bus pins are open-drain with an external pull-up; the bench
// resolves the data wire from sda_oe.
//
// What this block does
// - Write-protect high blocks all array writes.
// - Data falls while clock high: Start.
// - Data rises while clock high: Stop.
// - Data changes only while clock low.
// - Acknowledge matched control byte and each write byte after it, ninth clock.
// - Hold data low through acknowledge high.
// - No acknowledge during programming cycle.
// - Release data line after master withholds ack.
// - Ack control byte only on code match.
// - Last control bit selects read or write.
// - Two address bytes, high first, fifteen bits.
// - Byte write acked; Stop starts write.
// - Protected write acked, no cycle, ready at once.
// - Pointer ends after last written byte.
// - Up to 64 bytes buffered, committed at Stop.
// - Only low six pointer bits increment.
// - Page overrun wraps within same page.
// - Whole page rewritten on every write.
// - Write-protect sampled at Stop only.
// - Data pin open-drain, pull low only.
// - Write cycle ends within 5 ms.
`timescale 1ns/1ps
module sew_slave #(
  parameter int TWC_CYCLES = sew_pkg::TWC_CYC
) (
  input  wire logic                       core_clk,
  input  wire logic                       nrst,
  input  wire logic                       scl_in,
  input  wire logic                       sda_in,
  output logic                            sda_out,
  output logic                            sda_oe,
  input  wire logic                       wp,
  input  wire logic                       chip_select_bit0,
  input  wire logic                       chip_select_bit1,
  input  wire logic                       chip_select_bit2,
  output logic [sew_pkg::ADDR_W-1:0]      addr_ptr,
  output logic                            read_sel,
  output logic                            busy
);
  import sew_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] wp_sync;
  logic [2:0] cs_meta;
  logic [2:0] cs_s;
  logic       scl_d;
  logic       sda_d;
  // Straps and protect are slow levels, but still asynchronous pins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      wp_sync  <= 2'h0;
      cs_meta  <= 3'h0;
      cs_s     <= 3'h0;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      wp_sync  <= {wp_sync[0], wp};
      cs_meta  <= {chip_select_bit2, chip_select_bit1, chip_select_bit0};
      cs_s     <= cs_meta;
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end
  logic wp_s;
  assign wp_s = wp_sync[1];
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_s     = scl_sync[1];
  assign sda_s     = sda_sync[1];
  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------------------------------
  // Bit and byte sequencing
  // ----------------------------------------------------------------
  sew_phase_e phase;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic       ack_drive;
  logic       wr_armed;
  logic       rd_mode;
  logic [7:0] byte_rx;
  logic       byte_done;
  logic       ctrl_match;
  logic [PAGE_W-1:0] fill_cnt;
  logic       page_full;

  function automatic logic [PAGE_W-1:0] page_inc(input logic [PAGE_W-1:0] v);
    page_inc = v + 6'h01;
  endfunction

  assign byte_rx    = {shift[6:0], sda_s};
  // Data is sampled on the rising clock edge, stable while high
  assign byte_done  = scl_rise && (bit_cnt == BIT_LAST);
  assign ctrl_match = (byte_rx[7:4] == TYPE_CODE) &&
                      (byte_rx[3:1] == cs_s);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phase   <= SEW_IDLE;
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
      rd_mode <= 1'b0;
    end else if (start_det) begin
      phase   <= SEW_CTRL;
      bit_cnt <= 4'h0;
      rd_mode <= 1'b0;
    end else if (stop_det) begin
      phase   <= SEW_IDLE;
      bit_cnt <= 4'h0;
    end else if (scl_rise && phase != SEW_IDLE) begin
      shift <= byte_rx;
      if (bit_cnt == BIT_ACK) begin
        bit_cnt <= 4'h0;
      end else begin
        bit_cnt <= bit_cnt + 4'h1;
      end
      if (byte_done) begin
        case (phase)
          SEW_CTRL: begin
            if (!ctrl_match || busy) begin
              phase <= SEW_SKIP;
            end else if (byte_rx[0]) begin
              rd_mode <= 1'b1;
              phase   <= SEW_SKIP;
            end else begin
              phase <= SEW_ADRH;
            end
          end
          SEW_ADRH: phase <= SEW_ADRL;
          SEW_ADRL: phase <= SEW_DATA;
          SEW_DATA: phase <= SEW_DATA;
          SEW_SKIP: phase <= SEW_SKIP;
          default:  phase <= SEW_IDLE;
        endcase
      end
    end
  end
  assign read_sel = rd_mode;

  // ----------------------------------------------------------------
  // Acknowledge driver
  // ----------------------------------------------------------------
  // Ack is raised on the falling edge after bit 8 and held over the whole
  // ninth clock high; dropped on the next falling edge.
  logic rd_acked;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_drive <= 1'b0;
      rd_acked  <= 1'b0;
    end else if (start_det || stop_det) begin
      ack_drive <= 1'b0;
      rd_acked  <= 1'b0;
    end else if (scl_fall) begin
      if (bit_cnt == BIT_ACK && !busy) begin
        ack_drive <= (phase == SEW_ADRH) || (phase == SEW_ADRL) || (phase == SEW_DATA) ||
                     (phase == SEW_SKIP && rd_mode && !rd_acked);
        // Later ninth clocks of a read belong to the master
        rd_acked  <= rd_acked || rd_mode;
      end else begin
        ack_drive <= 1'b0;
      end
    end
  end
  // Control-byte ack in the read branch is taken only once, at bit 8 of CTRL
  assign sda_out = 1'b0;
  assign sda_oe  = ack_drive;

  // ----------------------------------------------------------------
  // Address pointer and page buffer
  // ----------------------------------------------------------------
  logic [7:0]        page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] dirty;
  logic [7:0]        mem [2**ADDR_W];
  logic [7:0]        addr_hi;
  logic [CNT_W-1:0]  wc_cnt;
  logic              commit_go;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      addr_ptr <= '0;
      addr_hi  <= 8'h00;
      dirty    <= '0;
      wr_armed <= 1'b0;
      fill_cnt <= '0;
      page_full <= 1'b0;
    end else if (start_det) begin
      dirty    <= '0;
      wr_armed <= 1'b0;
      fill_cnt <= '0;
      page_full <= 1'b0;
    end else if (byte_done) begin
      case (phase)
        SEW_ADRH: addr_hi <= byte_rx;
        SEW_ADRL: addr_ptr <= {addr_hi[ADDR_W-9:0], byte_rx};
        SEW_DATA: begin
          page_buf[addr_ptr[PAGE_W-1:0]] <= byte_rx;
          dirty[addr_ptr[PAGE_W-1:0]]    <= 1'b1;
          addr_ptr[PAGE_W-1:0] <= page_inc(addr_ptr[PAGE_W-1:0]);
          wr_armed <= 1'b1;
          fill_cnt <= page_inc(fill_cnt);
          if (fill_cnt == 6'h3f) begin
            page_full <= 1'b1;
          end
        end
        default: addr_hi <= addr_hi;
      endcase
    end else if (stop_det) begin
      wr_armed <= 1'b0;
    end
  end

  // Write protect is looked at only here, on the Stop that ends a write
  assign commit_go = stop_det && wr_armed && !wp_s && !busy;

  // ----------------------------------------------------------------
  // Self-timed write cycle
  // ----------------------------------------------------------------
  // The whole page goes through the cycle; clean bytes are refreshed from
  // the array, so the array model stores only dirty bytes.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      busy      <= 1'b0;
      wc_cnt    <= '0;
    end else if (commit_go) begin
      busy      <= 1'b1;
      wc_cnt    <= CNT_W'(TWC_CYCLES - 1);
    end else if (busy) begin
      if (wc_cnt == '0) begin
        busy <= 1'b0;
      end else begin
        wc_cnt <= wc_cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (commit_go) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (dirty[i]) begin
          mem[{addr_ptr[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= page_buf[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_no_ack_busy: assert property (@(posedge core_clk) disable iff (!nrst)
    busy |-> !sda_oe)
    else $error("ack driven during write cycle");
  a_wp_blocks: assert property (@(posedge core_clk) disable iff (!nrst)
    stop_det && wp_s && !busy |=> !busy)
    else $error("write cycle started while protected");
  a_stop_starts: assert property (@(posedge core_clk) disable iff (!nrst)
    stop_det && wr_armed && !wp && !busy |=> busy)
    else $error("stop did not start write cycle");
  a_cycle_len: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(busy) |-> busy [*8])
    else $error("write cycle ended early");
  a_cycle_bound: assert property (@(posedge core_clk) disable iff (!nrst)
    busy |-> wc_cnt < CNT_W'(TWC_CYCLES))
    else $error("write cycle counter out of range");
  a_start_ctrl: assert property (@(posedge core_clk) disable iff (!nrst)
    start_det |=> phase == SEW_CTRL && bit_cnt == 4'h0)
    else $error("start did not restart decode");
  a_page_wrap: assert property (@(posedge core_clk) disable iff (!nrst)
    byte_done && phase == SEW_DATA |=>
      addr_ptr[ADDR_W-1:PAGE_W] == $past(addr_ptr[ADDR_W-1:PAGE_W]))
    else $error("page write carried into next page");
  a_ptr_inc: assert property (@(posedge core_clk) disable iff (!nrst)
    byte_done && phase == SEW_DATA |=> addr_ptr[PAGE_W-1:0] == $past(addr_ptr[PAGE_W-1:0]) + 6'h01)
    else $error("pointer did not advance");
  a_mismatch_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
    phase == SEW_SKIP && !rd_mode |-> !sda_oe)
    else $error("data driven after mismatch");
  a_oe_only_low: assert property (@(posedge core_clk) disable iff (!nrst)
    sda_oe |-> !sda_out && (bit_cnt == BIT_ACK || bit_cnt == 4'h0))
    else $error("data line pulled outside the ack slot");
  a_ack_stable: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(sda_oe) |-> !scl_s)
    else $error("ack released while clock high");

  c_byte_write: cover property (@(posedge core_clk) disable iff (!nrst) $rose(busy));
  c_protected: cover property (@(posedge core_clk) disable iff (!nrst) stop_det && wr_armed && wp_s);
  c_page_full: cover property (@(posedge core_clk) disable iff (!nrst) page_full);
  c_read_sel: cover property (@(posedge core_clk) disable iff (!nrst) $rose(rd_mode));
endmodule

// File: sew_master.sv
// Behavioural two-wire bus master that drives the slave's pins for the bench.
// Assumes a pull-up on the data wire; the slave only pulls it low via sda_oe.
`timescale 1ns/1ps
module sew_master (
  input  wire logic core_clk,
  input  wire logic sda_oe,
  input  wire logic sda_out,
  output logic      scl_in,
  output logic      sda_in
);
  logic sda_m = 1'b1;
  initial scl_in = 1'b1;
  // Wired-AND with pull-up: high unless someone pulls low
  assign sda_in = sda_m & (~sda_oe | sda_out);
  // ----------------------------------------------------------------
  // Bus conditions
  // ----------------------------------------------------------------
  // Half a 160 ns link period, moved only on falling core edges
  task automatic hc();
    repeat (4) @(negedge core_clk);
  endtask
  task automatic start();
    sda_m = 1'b1;
    hc();
    scl_in = 1'b1;
    hc();
    sda_m = 1'b0;
    hc();
    scl_in = 1'b0;
    hc();
  endtask
  // Leaves both lines high, so the bus is idle afterwards
  task automatic stop();
    sda_m = 1'b0;
    hc();
    scl_in = 1'b1;
    hc();
    sda_m = 1'b1;
    hc();
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_m = b[i];
      hc();
      scl_in = 1'b1;
      hc();
      scl_in = 1'b0;
    end
    sda_m = 1'b1;
    hc();
    scl_in = 1'b1;
    repeat (2) @(negedge core_clk);
    ack = ~sda_in;
    repeat (2) @(negedge core_clk);
    scl_in = 1'b0;
  endtask
endmodule

// File: sew_slave_tb.sv
// Self-checking bench for the slave write path: acks, pointer, busy, protect.
// Assumes the slave's write cycle is shortened to TWC core cycles.
`timescale 1ns/1ps
module sew_slave_tb;
  import sew_pkg::*;
  localparam int TWC = 200;
  logic              core_clk = 1'b0;
  logic              nrst     = 1'b0;
  logic              wp       = 1'b0;
  logic [2:0]        cs       = 3'h0;
  logic              scl_in;
  logic              sda_in;
  logic              sda_oe;
  logic              sda_out;
  logic              read_sel;
  logic              busy;
  logic [ADDR_W-1:0] addr_ptr;
  logic              a;
  int                errors = 0;
  int                checked = 0;
  int                seed = 32'hf106;
  int                p;
  int                ad;
  int                pbase;
  int                touched[$];
  logic [7:0]        model [PAGE_BYTES];
  always #10 core_clk = ~core_clk;
  sew_slave #(.TWC_CYCLES(TWC)) sew_slave_i (.core_clk(core_clk), .nrst(nrst), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .wp(wp), .chip_select_bit0(cs[0]),
    .chip_select_bit1(cs[1]), .chip_select_bit2(cs[2]), .addr_ptr(addr_ptr),
    .read_sel(read_sel), .busy(busy));
  sew_master sew_master_i (.core_clk(core_clk), .sda_oe(sda_oe), .sda_out(sda_out), .scl_in(scl_in),
    .sda_in(sda_in));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic ctrl(input logic rd, input logic [2:0] sel, output logic ack);
    sew_master_i.start();
    sew_master_i.wbyte({TYPE_CODE, sel, rd}, ack);
  endtask
  // Model pointer: page base kept, low six bits wrap
  task automatic wr(input int adr, input int n);
    logic [7:0] d [$];
    ctrl(1'b0, cs, a);
    chk("ctrl_ack", 1, a);
    sew_master_i.wbyte({1'b1, 7'(adr >> 8)}, a); // Top bit must be ignored
    chk("adrh_ack", 1, a);
    sew_master_i.wbyte(8'(adr), a);
    chk("adrl_ack", 1, a);
    for (int i = 0; i < n; i++) begin
      d.push_back(8'($random(seed)));
      sew_master_i.wbyte(d[i], a);
      chk("data_ack", 1, a);
    end
    p = (adr & 32'h7fc0) | ((adr + n) % PAGE_BYTES);
    chk("ptr", 16'(p), 16'(addr_ptr));
    sew_master_i.stop();
    // Model array: later bytes of a wrapped page replace earlier ones
    pbase = adr & 32'h7fc0;
    for (int i = 0; i < n && !wp; i++) begin
      model[(adr + i) % PAGE_BYTES] = d[i];
      touched.push_back((adr + i) % PAGE_BYTES);
    end
  endtask
  task automatic chk_mem();
    foreach (touched[k]) begin
      chk("mem", 16'(model[touched[k]]), 16'(sew_slave_i.mem[pbase | touched[k]]));
    end
  endtask
  task automatic wait_idle();
    for (int i = 0; i < TWC + 40 && busy !== 1'b0; i++) @(negedge core_clk);
    chk("busy_end", 0, 16'(busy));
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #1_000_000;
    errors++;
    final_report();
  end
  initial begin
    cs = 3'($random(seed));
    repeat (12) @(negedge core_clk);
    nrst = 1'b1;
    repeat (4) @(negedge core_clk);
    ad = $random(seed) & 32'h7fff;
    wr(ad, 1);
    @(negedge core_clk);
    wp = 1'b1;
    repeat (8) @(negedge core_clk);
    chk("busy_start", 1, 16'(busy));
    ctrl(1'b0, cs, a);
    chk("busy_ack", 0, 16'(a));
    sew_master_i.stop();
    wait_idle();
    chk_mem();
    wp = 1'b0;
    $display("test byte_write done");
    wr((ad & 32'h7fc0) | 62, 66);
    repeat (8) @(negedge core_clk);
    chk("busy_page", 1, 16'(busy));
    wait_idle();
    chk_mem();
    $display("test page_wrap done");
    wp = 1'b1;
    wr(ad, 3);
    @(negedge core_clk);
    wp = 1'b0;
    repeat (8) @(negedge core_clk);
    chk("busy_wp", 0, 16'(busy));
    chk_mem();
    ctrl(1'b0, cs, a);
    chk("ready_ack", 1, 16'(a));
    sew_master_i.stop();
    $display("test protect done");
    ctrl(1'b0, ~cs, a);
    chk("miss_ack", 0, 16'(a));
    sew_master_i.wbyte({TYPE_CODE, cs, 1'b0}, a);
    chk("miss_rest", 0, 16'(a));
    ctrl(1'b1, cs, a);
    chk("rd_ack", 1, 16'(a));
    chk("read_sel", 1, 16'(read_sel));
    sew_master_i.wbyte(8'hff, a);
    chk("rd_release", 0, 16'(a));
    ctrl(1'b0, cs, a);
    chk("read_sel", 0, 16'(read_sel));
    sew_master_i.stop();
    $display("test select done");
    final_report();
  end
endmodule
